// ### logic/reg_attr_map.svh
// constants for the register bit attribute cells: indices, widths, reset values,
// immunity masks. assumes inclusion from the bank and the bench only.
`ifndef REG_ATTR_MAP_SVH
`define REG_ATTR_MAP_SVH

// ---------------------------------------------------------------
// access port geometry
// ---------------------------------------------------------------
`define RA_SEL_W 3
`define RA_DATA_W 8

// ---------------------------------------------------------------
// register indices on the access port
// ---------------------------------------------------------------
`define RA_IDX_W1C 3'h0
`define RA_IDX_ANYCLR 3'h1
`define RA_IDX_CNT 3'h2
`define RA_IDX_LATCH 3'h3
`define RA_IDX_PHY 3'h4
`define RA_IDX_CTRL 3'h5
`define RA_IDX_STAT 3'h6

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RA_RST_W1C 8'h00
`define RA_RST_ANYCLR 8'h00
`define RA_RST_CNT 8'h00
`define RA_RST_LATCH 8'h00
`define RA_RST_PHY 8'h00
`define RA_RST_CTRL 8'h00

// ---------------------------------------------------------------
// per-bit immunity masks (1 = bit keeps its value on that reset class)
// ---------------------------------------------------------------
`define RA_W1C_KEEP_LITE 8'h01
`define RA_W1C_KEEP_SW 8'h00
`define RA_W1C_STICKY 8'h80
`define RA_CTRL_KEEP_LITE 8'h80
`define RA_CTRL_KEEP_SW 8'h40
`define RA_CTRL_STICKY 8'h20

// ---------------------------------------------------------------
// control register field layout
// ---------------------------------------------------------------
`define RA_CTRL_SELFCLR_LSB 0
`define RA_CTRL_SELFCLR_W 4
`define RA_CTRL_W1S_LSB 4
`define RA_STAT_READY_BIT 0
// latch register: bits below this latch low, bits from it up latch high
`define RA_LAT_HIGH_LSB 4

`endif

// ### logic/reg_attr_pkg.sv
// types shared by the attribute cell and the top module.
// assumes nothing of its surroundings.
`default_nettype none

package reg_attr_pkg;

   // ---------------------------------------------------------------
   // bit attribute kinds
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      write_one_clears,
      write_any_clears,
      latch_low_clear_on_read,
      latch_high_clear_on_read,
      phy_readonly_high_latch,
      self_clearing,
      write_one_sets
   } attr_kind_e;

endpackage

`default_nettype wire

// ### logic/attr_bit_cell.sv
// one storage bit with a selectable access attribute and reset immunity.
// assumes access strobes and soft reset pulses are on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module attr_bit_cell #(
   parameter reg_attr_pkg::attr_kind_e KIND = reg_attr_pkg::write_one_clears,
   parameter bit KEEP_LITE = 1'b0,
   parameter bit KEEP_SW = 1'b0,
   parameter bit STICKY = 1'b0,
   parameter bit RST_VAL = 1'b0
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic lite_rst,
   input wire logic sw_rst,
   input wire logic hot_rst,
   input wire logic rd_hit,
   input wire logic wr_hit,
   input wire logic wr_bit,
   input wire logic hw_in,
   output logic bit_reg
);

   logic bit_next;
   logic rst_hit;

   // ---------------------------------------------------------------
   // reset classes, filtered by the immunity flags
   // ---------------------------------------------------------------
   // hot reset input already merges function-level reset
   assign rst_hit = (lite_rst && !KEEP_LITE)
                  || (sw_rst && !KEEP_SW)
                  || (hot_rst && !STICKY);

   // next value by attribute; hardware set always beats a clearing access
   always_comb begin
      case (KIND)
         reg_attr_pkg::write_one_clears: begin
            bit_next = hw_in || (bit_reg && !(wr_hit && wr_bit));
         end
         reg_attr_pkg::write_any_clears: begin
            bit_next = hw_in || (bit_reg && !wr_hit);
         end
         reg_attr_pkg::latch_low_clear_on_read: begin
            // a low seen in the read cycle stays latched
            bit_next = rd_hit ? hw_in : (bit_reg && hw_in);
         end
         reg_attr_pkg::latch_high_clear_on_read: begin
            bit_next = hw_in || (bit_reg && !rd_hit);
         end
         reg_attr_pkg::phy_readonly_high_latch: begin
            bit_next = rd_hit ? hw_in : (bit_reg || hw_in);
         end
         reg_attr_pkg::self_clearing: begin
            // one cycle high: the action starts on that cycle
            bit_next = wr_hit && wr_bit;
         end
         default: begin
            bit_next = bit_reg || (wr_hit && wr_bit);
         end
      endcase
   end

   // storage flop
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bit_reg <= RST_VAL;
      end else if (rst_hit) begin
         bit_reg <= RST_VAL;
      end else begin
         bit_reg <= bit_next;
      end
   end

endmodule

`default_nettype wire

// ### logic/reg_attr_bank.sv
// register bank built from attribute cells, with a plain access port.
// assumes access strobes, soft resets and init_done come from sys_clk logic.
`timescale 1ns/1ps
`default_nettype none
`include "reg_attr_map.svh"

module reg_attr_bank (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic lite_rst,
   input wire logic sw_rst,
   input wire logic hot_rst,
   input wire logic flr_rst,
   input wire logic init_done,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [`RA_SEL_W-1:0] acc_sel,
   input wire logic [`RA_DATA_W-1:0] wr_data,
   input wire logic [`RA_DATA_W-1:0] hw_evt,
   input wire logic cnt_inc,
   input wire logic [3:0] cond_low,
   input wire logic [3:0] cond_high,
   input wire logic [`RA_DATA_W-1:0] phy_cond,
   output logic [`RA_DATA_W-1:0] rd_data_reg,
   output logic ready_reg,
   output logic [`RA_CTRL_SELFCLR_W-1:0] cmd_pulse,
   output logic [3:0] ctrl_en
);

   localparam int W = `RA_DATA_W;
   localparam logic [W-1:0] W1C_LITE = `RA_W1C_KEEP_LITE;
   localparam logic [W-1:0] W1C_SW = `RA_W1C_KEEP_SW;
   localparam logic [W-1:0] W1C_STK = `RA_W1C_STICKY;
   localparam logic [W-1:0] W1C_RST = `RA_RST_W1C;
   localparam logic [W-1:0] ANYCLR_RST = `RA_RST_ANYCLR;
   localparam logic [W-1:0] LAT_RST = `RA_RST_LATCH;
   localparam logic [W-1:0] PHY_RST = `RA_RST_PHY;
   localparam logic [W-1:0] CTL_LITE = `RA_CTRL_KEEP_LITE;
   localparam logic [W-1:0] CTL_SW = `RA_CTRL_KEEP_SW;
   localparam logic [W-1:0] CTL_STK = `RA_CTRL_STICKY;
   localparam logic [W-1:0] CTL_RST = `RA_RST_CTRL;

   logic hot_any;
   logic any_rst;
   logic [W-1:0] w1c_q;
   logic [W-1:0] anyclr_q;
   logic [W-1:0] lat_q;
   logic [W-1:0] lat_in;
   logic [W-1:0] phy_q;
   logic [W-1:0] ctl_q;
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic [W-1:0] rd_data_next;
   logic ready_next;
   logic rd_w1c, rd_anyclr, rd_cnt, rd_lat, rd_phy, rd_ctl;
   logic wr_w1c, wr_anyclr, wr_cnt, wr_lat, wr_phy, wr_ctl;

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   // shared by the read and the write strobes
   function automatic logic sel_is(input logic [`RA_SEL_W-1:0] sel,
                                   input logic [`RA_SEL_W-1:0] idx);
      sel_is = (sel == idx);
   endfunction

   assign rd_w1c = rd_stb && sel_is(acc_sel, `RA_IDX_W1C);
   assign rd_anyclr = rd_stb && sel_is(acc_sel, `RA_IDX_ANYCLR);
   assign rd_cnt = rd_stb && sel_is(acc_sel, `RA_IDX_CNT);
   assign rd_lat = rd_stb && sel_is(acc_sel, `RA_IDX_LATCH);
   assign rd_phy = rd_stb && sel_is(acc_sel, `RA_IDX_PHY);
   assign rd_ctl = rd_stb && sel_is(acc_sel, `RA_IDX_CTRL);
   assign wr_w1c = wr_stb && sel_is(acc_sel, `RA_IDX_W1C);
   assign wr_anyclr = wr_stb && sel_is(acc_sel, `RA_IDX_ANYCLR);
   assign wr_cnt = wr_stb && sel_is(acc_sel, `RA_IDX_CNT);
   assign wr_lat = wr_stb && sel_is(acc_sel, `RA_IDX_LATCH);
   assign wr_phy = wr_stb && sel_is(acc_sel, `RA_IDX_PHY);
   assign wr_ctl = wr_stb && sel_is(acc_sel, `RA_IDX_CTRL);

   // function-level reset acts exactly like hot reset on every cell
   assign hot_any = hot_rst || flr_rst;
   assign any_rst = lite_rst || sw_rst || hot_any;
   // low nibble latches low, high nibble latches high
   assign lat_in = {cond_high, cond_low};

   // ---------------------------------------------------------------
   // cell arrays, one generate loop covering every register except the counter and status
   // ---------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_bits
      // event flags cleared by writing one
      attr_bit_cell #(
         .KIND(reg_attr_pkg::write_one_clears),
         .KEEP_LITE(W1C_LITE[i]),
         .KEEP_SW(W1C_SW[i]),
         .STICKY(W1C_STK[i]),
         .RST_VAL(W1C_RST[i])
      ) u_w1c (
         .sys_clk(sys_clk), .nrst(nrst), .lite_rst(lite_rst), .sw_rst(sw_rst),
         .hot_rst(hot_any), .rd_hit(rd_w1c), .wr_hit(wr_w1c),
         .wr_bit(wr_data[i]), .hw_in(hw_evt[i]), .bit_reg(w1c_q[i])
      );
      // same events, cleared by any write
      attr_bit_cell #(
         .KIND(reg_attr_pkg::write_any_clears),
         .RST_VAL(ANYCLR_RST[i])
      ) u_anyclr (
         .sys_clk(sys_clk), .nrst(nrst), .lite_rst(lite_rst), .sw_rst(sw_rst),
         .hot_rst(hot_any), .rd_hit(rd_anyclr), .wr_hit(wr_anyclr),
         .wr_bit(wr_data[i]), .hw_in(hw_evt[i]), .bit_reg(anyclr_q[i])
      );
      // latched conditions, released by a read
      attr_bit_cell #(
         .KIND(i < `RA_LAT_HIGH_LSB ? reg_attr_pkg::latch_low_clear_on_read
                     : reg_attr_pkg::latch_high_clear_on_read),
         .RST_VAL(LAT_RST[i])
      ) u_lat (
         .sys_clk(sys_clk), .nrst(nrst), .lite_rst(lite_rst), .sw_rst(sw_rst),
         .hot_rst(hot_any), .rd_hit(rd_lat), .wr_hit(wr_lat),
         .wr_bit(wr_data[i]), .hw_in(lat_in[i]), .bit_reg(lat_q[i])
      );
      // phy status: high until read, then tracks the cause
      attr_bit_cell #(
         .KIND(reg_attr_pkg::phy_readonly_high_latch),
         .RST_VAL(PHY_RST[i])
      ) u_phy (
         .sys_clk(sys_clk), .nrst(nrst), .lite_rst(lite_rst), .sw_rst(sw_rst),
         .hot_rst(hot_any), .rd_hit(rd_phy), .wr_hit(wr_phy),
         .wr_bit(wr_data[i]), .hw_in(phy_cond[i]), .bit_reg(phy_q[i])
      );
      // control: low nibble self-clearing commands, high nibble write-one-sets enables
      attr_bit_cell #(
         .KIND(i < `RA_CTRL_W1S_LSB ? reg_attr_pkg::self_clearing
                                    : reg_attr_pkg::write_one_sets),
         .KEEP_LITE(CTL_LITE[i]),
         .KEEP_SW(CTL_SW[i]),
         .STICKY(CTL_STK[i]),
         .RST_VAL(CTL_RST[i])
      ) u_ctl (
         .sys_clk(sys_clk), .nrst(nrst), .lite_rst(lite_rst), .sw_rst(sw_rst),
         .hot_rst(hot_any), .rd_hit(rd_ctl), .wr_hit(wr_ctl),
         .wr_bit(wr_data[i]), .hw_in(1'b0), .bit_reg(ctl_q[i])
      );
   end

   // cell flops drive these outputs directly
   assign cmd_pulse = ctl_q[`RA_CTRL_SELFCLR_LSB +: `RA_CTRL_SELFCLR_W];
   assign ctrl_en = ctl_q[W-1:`RA_CTRL_W1S_LSB];

   // ---------------------------------------------------------------
   // read-clears event counter
   // ---------------------------------------------------------------
   // an increment in the read cycle survives as a count of one
   always_comb begin
      if (rd_cnt) begin
         cnt_next = {{(W-1){1'b0}}, cnt_inc};
      end else if (cnt_inc && cnt_reg != {W{1'b1}}) begin
         cnt_next = cnt_reg + 8'h01; // saturates rather than wrapping
      end else begin
         cnt_next = cnt_reg; // writes are ignored here
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= `RA_RST_CNT;
      end else if (any_rst) begin
         cnt_reg <= `RA_RST_CNT;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ---------------------------------------------------------------
   // ready flag
   // ---------------------------------------------------------------
   // dropped by any soft reset so software never sees a half-reset block
   assign ready_next = init_done && !any_rst;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= ready_next;
      end
   end

   // ---------------------------------------------------------------
   // read data capture
   // ---------------------------------------------------------------
   // values are sampled before the same-edge clear takes effect
   always_comb begin
      if (acc_sel == `RA_IDX_W1C) begin
         rd_data_next = w1c_q;
      end else if (acc_sel == `RA_IDX_ANYCLR) begin
         rd_data_next = anyclr_q;
      end else if (acc_sel == `RA_IDX_CNT) begin
         rd_data_next = cnt_reg;
      end else if (acc_sel == `RA_IDX_LATCH) begin
         rd_data_next = lat_q;
      end else if (acc_sel == `RA_IDX_PHY) begin
         rd_data_next = phy_q;
      end else if (acc_sel == `RA_IDX_CTRL) begin
         rd_data_next = ctl_q;
      end else if (acc_sel == `RA_IDX_STAT) begin
         rd_data_next = {{(W-1){1'b0}}, ready_reg};
      end else begin
         rd_data_next = {W{1'b0}}; // unmapped and reserved read as zero
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_reg <= {W{1'b0}};
      end else if (rd_stb) begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   AST_ANYCLR_ANY_WRITE: assert property (
      wr_anyclr && !hw_evt[1] |=> !anyclr_q[1])
      else $error("write-any-clears bit survived a write");

   AST_RDCLR_READ_RETURN: assert property (
      rd_cnt && !cnt_inc && !any_rst |=> rd_data_reg == $past(cnt_reg) && cnt_reg == 8'h00)
      else $error("read-clears counter not returned then cleared");

   AST_RDCLR_WRITE_IGNORED: assert property (
      wr_cnt && !rd_stb && !cnt_inc && !any_rst |=> $stable(cnt_reg))
      else $error("write changed the read-clears counter");

   AST_LATLOW_HOLD_LOW: assert property (
      !lat_q[0] && !rd_lat |=> !lat_q[0])
      else $error("latch-low bit released without a read");

   AST_LATHIGH_HOLD_HIGH: assert property (
      lat_q[4] && !rd_lat && !any_rst |=> lat_q[4])
      else $error("latch-high bit released without a read");

   AST_SELFCLR_ONE_CYCLE: assert property (
      wr_ctl && wr_data[0] && !any_rst ##1 !(wr_ctl && wr_data[0])
      |-> cmd_pulse[0] ##1 !cmd_pulse[0])
      else $error("self-clearing bit did not pulse for one cycle");

   AST_SELFCLR_ZERO_WRITE: assert property (
      wr_ctl && !wr_data[0] |=> !cmd_pulse[0])
      else $error("writing zero raised a self-clearing bit");

   AST_PHY_FOLLOW: assert property (
      rd_phy && !phy_cond[2] |=> !phy_q[2])
      else $error("phy latch bit did not follow its cause after read");

   AST_PHY_HOLD: assert property (
      phy_q[2] && !rd_phy && !any_rst |=> phy_q[2])
      else $error("phy latch bit dropped before read");

   AST_LITE_KEEP: assert property (
      lite_rst && !sw_rst && !hot_any && ctl_q[7] |=> ctl_q[7])
      else $error("lite-reset-immune bit was reset");

   AST_LITE_RESETS_OTHERS: assert property (
      lite_rst |=> !ctl_q[4] && cnt_reg == 8'h00)
      else $error("lite reset missed an ordinary bit");

   AST_SW_KEEP: assert property (
      sw_rst && !lite_rst && !hot_any && ctl_q[6] |=> ctl_q[6])
      else $error("software-reset-immune bit was reset");

   AST_STICKY_KEEP: assert property (
      hot_any && !lite_rst && !sw_rst && ctl_q[5] |=> ctl_q[5])
      else $error("sticky bit changed on hot or function reset");

   AST_READY_ONLY_WHEN_DONE: assert property (
      ready_reg |-> $past(init_done) && !$past(any_rst))
      else $error("ready set before initialization finished");

   AST_READY_RISES: assert property (
      init_done && !any_rst |=> ready_reg)
      else $error("ready not set after initialization");

   AST_W1C_ONE: assert property (
      wr_w1c && wr_data[1] && !hw_evt[1] |=> !w1c_q[1])
      else $error("write-one-clears bit not cleared");

   AST_W1C_ZERO: assert property (
      w1c_q[2] && wr_w1c && !wr_data[2] && !any_rst |=> w1c_q[2])
      else $error("writing zero cleared a write-one-clears bit");

   AST_W1S_ONE: assert property (
      wr_ctl && wr_data[4] && !any_rst |=> ctrl_en[0])
      else $error("write-one-sets bit not set");

   AST_SET_BEATS_CLEAR: assert property (
      hw_evt[3] && (wr_w1c || wr_anyclr) && !any_rst |=> w1c_q[3] && anyclr_q[3])
      else $error("event lost against a same-cycle clear");

endmodule

`default_nettype wire

// ### verif/register_bit_attribute_cells_tb.sv
// self-checking bench for the register bit attribute bank.
// assumes the bank's access port as handed over: one-cycle strobes, read data one edge late.
`timescale 1ns/1ps
`default_nettype none
`include "reg_attr_map.svh"

module register_bit_attribute_cells_tb;

   // ---------------------------------------------------------------
   // stimulus and observation signals
   // ---------------------------------------------------------------
   logic sys_clk, nrst, lite_rst, sw_rst, hot_rst, flr_rst, init_done;
   logic rd_stb, wr_stb, cnt_inc, ready_reg;
   logic [`RA_SEL_W-1:0] acc_sel;
   logic [`RA_DATA_W-1:0] wr_data, hw_evt, phy_cond, rd_data_reg, d;
   logic [3:0] cond_low, cond_high, cmd_pulse, ctrl_en, pulse_seen;
   logic [7:0] w1c_exp [4] = '{8'h01, 8'h00, 8'h80, 8'h80};
   logic [3:0] en_exp [4] = '{4'h8, 4'h4, 4'h2, 4'h2};
   int fails, checked, cycles;

   // x never matches a known expected value, so an unknown output always counts as a mismatch
   `define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin fails++; \
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp); end end

   reg_attr_bank DUT (.sys_clk(sys_clk), .nrst(nrst), .lite_rst(lite_rst), .sw_rst(sw_rst),
      .hot_rst(hot_rst), .flr_rst(flr_rst), .init_done(init_done), .rd_stb(rd_stb),
      .wr_stb(wr_stb), .acc_sel(acc_sel), .wr_data(wr_data), .hw_evt(hw_evt),
      .cnt_inc(cnt_inc), .cond_low(cond_low), .cond_high(cond_high), .phy_cond(phy_cond),
      .rd_data_reg(rd_data_reg), .ready_reg(ready_reg), .cmd_pulse(cmd_pulse),
      .ctrl_en(ctrl_en));

   // ---------------------------------------------------------------
   // clock and hang guard
   // ---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // whole run is just over a hundred cycles; the ceiling leaves wide margin
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end

   // ---------------------------------------------------------------
   // access tasks: inputs move 1 ns after the edge, strobes drop
   // one cycle later so no signal is assigned twice in one step
   // ---------------------------------------------------------------
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic rd(input logic [2:0] idx, output logic [7:0] v);
      acc_sel = idx;
      rd_stb = 1'b1;
      tick();
      v = rd_data_reg;
      rd_stb = 1'b0;
      tick();
   endtask

   // evt rides in the same cycle as the write strobe
   task automatic wr(input logic [2:0] idx, input logic [7:0] v, input logic [7:0] evt);
      acc_sel = idx;
      wr_data = v;
      hw_evt = evt;
      wr_stb = 1'b1;
      tick();
      pulse_seen = cmd_pulse;
      wr_stb = 1'b0;
      hw_evt = 8'h00;
      tick();
   endtask

   task automatic evt_pulse(input logic [7:0] evt);
      hw_evt = evt;
      cnt_inc = 1'b1;
      tick();
      hw_evt = 8'h00;
      cnt_inc = 1'b0;
      tick();
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_ready();
      `CHK(ready_reg, 1'b0, "ready before init")
      init_done = 1'b1;
      tick();
      `CHK(ready_reg, 1'b1, "ready after init")
      rd(`RA_IDX_STAT, d);
      `CHK(d, 8'h01, "status read")
   endtask

   // latch-low resets low and stays low until a read releases it
   task automatic t_latch();
      rd(`RA_IDX_LATCH, d);
      `CHK(d, 8'h00, "latch first read")
      rd(`RA_IDX_LATCH, d);
      `CHK(d, 8'h0F, "latch released")
      cond_low = 4'hE;
      cond_high = 4'h2;
      tick();
      cond_low = 4'hF;
      cond_high = 4'h0;
      tick();
      `CHK(rd_data_reg, 8'h0F, "read data holds")
      rd(`RA_IDX_LATCH, d);
      `CHK(d, 8'h2E, "latched low and high")
      rd(`RA_IDX_LATCH, d);
      `CHK(d, 8'h0F, "latches cleared by read")
   endtask

   task automatic t_w1c_wac();
      evt_pulse(8'hFF);
      rd(`RA_IDX_W1C, d);
      `CHK(d, 8'hFF, "w1c set by event")
      wr(`RA_IDX_W1C, 8'h0F, 8'h00);
      rd(`RA_IDX_W1C, d);
      `CHK(d, 8'hF0, "w1c ones clear")
      wr(`RA_IDX_W1C, 8'h00, 8'h00);
      rd(`RA_IDX_W1C, d);
      `CHK(d, 8'hF0, "w1c zeros keep")
      wr(`RA_IDX_W1C, 8'hFF, 8'h80);
      rd(`RA_IDX_W1C, d);
      `CHK(d, 8'h80, "w1c event wins")
      evt_pulse(8'h3C);
      wr(`RA_IDX_ANYCLR, 8'h00, 8'h00);
      rd(`RA_IDX_ANYCLR, d);
      `CHK(d, 8'h00, "any-clear zero write clears")
      wr(`RA_IDX_ANYCLR, 8'hFF, 8'h01);
      rd(`RA_IDX_ANYCLR, d);
      `CHK(d, 8'h01, "any-clear event wins")
      wr(`RA_IDX_ANYCLR, 8'h5A, 8'h00);
      rd(`RA_IDX_ANYCLR, d);
      `CHK(d, 8'h00, "any-clear any write clears")
   endtask

   // counter holds 2 from the event pulses above; one more pulse makes 3
   task automatic t_count();
      evt_pulse(8'h00);
      wr(`RA_IDX_CNT, 8'hFF, 8'h00);
      rd(`RA_IDX_CNT, d);
      `CHK(d, 8'h03, "count returned, write ignored")
      rd(`RA_IDX_CNT, d);
      `CHK(d, 8'h00, "count cleared by read")
   endtask

   task automatic t_phy();
      phy_cond = 8'h01;
      tick();
      phy_cond = 8'h00;
      tick();
      rd(`RA_IDX_PHY, d);
      `CHK(d, 8'h01, "phy held after cause gone")
      rd(`RA_IDX_PHY, d);
      `CHK(d, 8'h00, "phy follows after read")
      phy_cond = 8'h02;
      tick();
      rd(`RA_IDX_PHY, d);
      phy_cond = 8'h00;
      rd(`RA_IDX_PHY, d);
      `CHK(d, 8'h02, "phy high while cause held")
      rd(`RA_IDX_PHY, d);
      `CHK(d, 8'h00, "phy low once cause gone")
   endtask

   task automatic t_ctrl();
      wr(`RA_IDX_CTRL, 8'h01, 8'h00);
      `CHK(pulse_seen, 4'h1, "self clear pulse")
      `CHK(cmd_pulse, 4'h0, "self clear dropped")
      wr(`RA_IDX_CTRL, 8'h30, 8'h00);
      wr(`RA_IDX_CTRL, 8'h00, 8'h00);
      `CHK(pulse_seen, 4'h0, "zero write no pulse")
      `CHK(ctrl_en, 4'h3, "w1s set, zeros keep")
      rd(`RA_IDX_CTRL, d);
      `CHK(d, 8'h30, "control readable")
   endtask

   // one pass per reset class: lite, software, hot, function-level
   task automatic t_soft_resets();
      for (int k = 0; k < 4; k++) begin
         evt_pulse(8'hFF);
         wr(`RA_IDX_CTRL, 8'hF0, 8'h00);
         lite_rst = (k == 0);
         sw_rst = (k == 1);
         hot_rst = (k == 2);
         flr_rst = (k == 3);
         tick();
         `CHK(ready_reg, 1'b0, "ready dropped by reset")
         {lite_rst, sw_rst, hot_rst, flr_rst} = 4'h0;
         tick();
         `CHK(ready_reg, 1'b1, "ready back")
         `CHK(ctrl_en, en_exp[k], "control immunity")
         rd(`RA_IDX_W1C, d);
         `CHK(d, w1c_exp[k], "status immunity")
      end
   endtask

   task automatic t_reserved();
      wr(`RA_IDX_STAT, 8'h00, 8'h00);
      rd(`RA_IDX_STAT, d);
      `CHK(d, 8'h01, "status write ignored")
      wr(3'h7, 8'h00, 8'h00);
      rd(3'h7, d);
      `CHK(d, 8'h00, "unmapped reads zero")
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      {lite_rst, sw_rst, hot_rst, flr_rst, init_done, rd_stb, wr_stb, cnt_inc} = 8'h00;
      acc_sel = 3'h0;
      wr_data = 8'h00;
      hw_evt = 8'h00;
      phy_cond = 8'h00;
      cond_low = 4'hF;
      cond_high = 4'h0;
      pulse_seen = 4'h0;
      repeat (2) tick();
      `CHK({rd_data_reg, ready_reg, cmd_pulse, ctrl_en}, 17'h00000, "outputs in reset")
      nrst = 1'b1;
      tick();
      t_ready();
      t_latch();
      t_w1c_wac();
      t_count();
      t_phy();
      t_ctrl();
      t_soft_resets();
      t_reserved();
      stop_test();
   end

   `undef CHK

endmodule

`default_nettype wire
